// >>> ufsp_cfg.svh
// ufsp_cfg.svh - offsets, field positions, reset values and timing counts of the flash port
`ifndef UFSP_CFG_SVH
`define UFSP_CFG_SVH

// ============================================================
// array geometry
`define UFSP_WORDS 512
`define UFSP_WORD_W 16
`define UFSP_ADDR_W 9
`define UFSP_SECTOR_BIT 8
`define UFSP_ERASED_WORD 16'hFFFF

// ============================================================
// register map (byte addresses on the AHB-Lite slave)
`define UFSP_OFF_CTRL 12'h000
`define UFSP_OFF_STATUS 12'h004
`define UFSP_OFF_DATA 12'h008
`define UFSP_CTRL_LIVE_BIT 0
`define UFSP_ST_BUSY_BIT 0
`define UFSP_ST_LIVE_BIT 1
`define UFSP_ST_SECTOR_BIT 2
`define UFSP_ST_DOUT_BIT 3
`define UFSP_ST_ADDR_LSB 16
`define UFSP_CTRL_RESET 1'b0

// ============================================================
// timing: hclk rate, oscillator rate, self-timed sequence lengths
`define UFSP_HCLK_KHZ 250000
`define UFSP_OSC_KHZ 15625
`define UFSP_OSC_HALF_CYC (`UFSP_HCLK_KHZ / (2 * `UFSP_OSC_KHZ))
`define UFSP_PROG_TIME_NS 40000
`define UFSP_ERASE_TIME_NS 400000
`define UFSP_PROG_CYC ((`UFSP_PROG_TIME_NS * (`UFSP_HCLK_KHZ / 1000) + 999) / 1000)
`define UFSP_ERASE_CYC ((`UFSP_ERASE_TIME_NS * (`UFSP_HCLK_KHZ / 1000) + 999) / 1000)

`endif

// >>> ufsp_pkg.sv
// ufsp_pkg.sv - types shared by the flash serial port
`default_nettype none
package ufsp_pkg;

  // ============================================================
  // sequencer states
  typedef enum logic [1:0] {
    UFSP_IDLE = 2'b00,
    UFSP_PROG = 2'b01,
    UFSP_ERASE = 2'b10
  } ufsp_state_t;

  // ============================================================
  // pins arriving from the controller in the logic array
  typedef struct packed {
    logic addr_shift_clock;
    logic addr_shift_select;
    logic addr_serial_in;
    logic data_shift_clock;
    logic data_shift_select;
    logic data_serial_in;
    logic program_req;
    logic erase_req;
    logic clock_gen_enable;
  } ufsp_pins_t;

endpackage : ufsp_pkg
`default_nettype wire

// >>> ufsp_top.sv
// ufsp_top.sv - user flash array with serial address/data port, sequencer and oscillator
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ufsp_cfg.svh"

// Function
// - 512 words of 16 bits stored
// - address top bit picks the sector
// - erase clears one whole sector only
// - shift select high: address shifts serially
// - shift select low: address increments by one
// - address register names the acted location
// - 16-bit data register with serial pins
// - data select high: data register shifts
// - data select low: parallel load (read)
// - serial output presents top bit first
// - program/erase rising edge starts sequencer
// - program writes data register to address
// - busy high from start until done
// - divided clock is oscillator over four
// - enable low holds divided clock low unless live update is on
// - oscillator runs only when needed
// - live update forces oscillator output on
// - address register is nine bits
// - increment from maximum wraps to zero
// - no new operation while busy
module ufsp_top #(
  parameter int unsigned PROG_CYCLES = `UFSP_PROG_CYC,
  parameter int unsigned ERASE_CYCLES = `UFSP_ERASE_CYC
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial flash port from the logic array
  input wire ufsp_pkg::ufsp_pins_t pins,
  // answers to the logic array
  output logic data_serial_out,
  output logic busy,
  output logic divided_clock_out,
  output logic live_update_busy
);
  import ufsp_pkg::*;

  localparam int unsigned OSC_HALF = `UFSP_OSC_HALF_CYC;
  localparam logic [7:0] OSC_HALF_M1 = 8'(OSC_HALF - 1);
  localparam logic [16:0] PROG_M1 = 17'(PROG_CYCLES - 1);
  localparam logic [16:0] ERASE_M1 = 17'(ERASE_CYCLES - 1);

  // ============================================================
  // state flags read by several sections below
  // busy and live update both gate the serial port, so they are declared ahead of their logic
  logic busy_reg;
  logic live_reg;

  // ============================================================
  // pin synchronisers: two flops, then one more for edge finding
  ufsp_pins_t sync1_reg;
  ufsp_pins_t sync2_reg;
  ufsp_pins_t prev_reg;

  // selects and serial data ride the same pipeline as their clocks, so they stay aligned
  // first stage is read only by the second stage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // edge and gating terms
  // a link edge counts once, on the third hclk after its rise; pulses under one hclk may be lost
  wire logic ar_edge;
  wire logic dr_edge;
  wire logic prog_edge;
  wire logic erase_edge;
  wire logic ops_ok;
  assign ar_edge = sync2_reg.addr_shift_clock & ~prev_reg.addr_shift_clock;
  assign dr_edge = sync2_reg.data_shift_clock & ~prev_reg.data_shift_clock;
  assign prog_edge = sync2_reg.program_req & ~prev_reg.program_req;
  assign erase_edge = sync2_reg.erase_req & ~prev_reg.erase_req;
  assign ops_ok = ~busy_reg & ~live_reg;

  // ============================================================
  // storage: contents plus a per-word written flag, so an erased word reads all ones
  // reset leaves contents alone; cleared flags make every word read as erased
  logic [`UFSP_WORD_W-1:0] mem [0:`UFSP_WORDS-1];
  logic [`UFSP_WORDS-1:0] written_reg;
  logic [`UFSP_ADDR_W-1:0] addr_reg;
  logic [`UFSP_ADDR_W-1:0] addr_next;
  logic [`UFSP_WORD_W-1:0] data_reg;
  logic [`UFSP_WORD_W-1:0] data_next;
  logic [`UFSP_ADDR_W-1:0] op_addr_reg;
  logic [`UFSP_WORD_W-1:0] op_data_reg;

  wire logic [`UFSP_WORD_W-1:0] cell_word;
  wire logic [`UFSP_WORD_W-1:0] rd_word;
  wire logic [`UFSP_WORD_W-1:0] prog_word;
  wire logic sector;
  assign cell_word = mem[addr_reg];
  assign rd_word = written_reg[addr_reg] ? cell_word : `UFSP_ERASED_WORD;
  assign sector = addr_reg[`UFSP_SECTOR_BIT];
  // programming only clears bits; new ones need an erase
  assign prog_word = op_data_reg & (written_reg[op_addr_reg] ? mem[op_addr_reg]
                                                             : `UFSP_ERASED_WORD);

  // ============================================================
  // address register: shift or increment; shifts are dropped while busy to protect the array
  // the link clock never clocks a flop here; its edges are retimed to hclk
  assign addr_next = !(ar_edge && ops_ok) ? addr_reg :
                     sync2_reg.addr_shift_select ?
                       {addr_reg[`UFSP_ADDR_W-2:0], sync2_reg.addr_serial_in} :
                       `UFSP_ADDR_W'(addr_reg + 9'h001);

  // data register: shift in at bit 0, top bit is the serial output
  // a parallel load reads the array combinationally at the current address
  assign data_next = !(dr_edge && ops_ok) ? data_reg :
                     sync2_reg.data_shift_select ?
                       {data_reg[`UFSP_WORD_W-2:0], sync2_reg.data_serial_in} :
                       rd_word;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_reg <= '0;
      data_reg <= '0;
    end else begin
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  assign data_serial_out = data_reg[`UFSP_WORD_W-1];

  // ============================================================
  // self-timed program/erase sequencer
  ufsp_state_t state_reg;
  ufsp_state_t state_next;
  logic [16:0] cnt_reg;
  logic [16:0] cnt_next;
  wire logic seq_done;
  wire logic start_prog;
  wire logic start_erase;
  wire logic commit_prog;
  wire logic commit_erase;
  assign seq_done = (cnt_reg == 17'h00000);
  // program wins if both rise together; that case is undefined for the array anyway
  assign start_prog = (state_reg == UFSP_IDLE) && ops_ok && prog_edge;
  assign start_erase = (state_reg == UFSP_IDLE) && ops_ok && erase_edge && !prog_edge;
  assign commit_prog = (state_reg == UFSP_PROG) && seq_done;
  assign commit_erase = (state_reg == UFSP_ERASE) && seq_done;

  // the counter loads the length minus one, so busy stands the full length
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      UFSP_IDLE: begin
        if (start_prog) begin
          state_next = UFSP_PROG;
          cnt_next = PROG_M1;
        end else if (start_erase) begin
          state_next = UFSP_ERASE;
          cnt_next = ERASE_M1;
        end
      end
      UFSP_PROG, UFSP_ERASE: begin
        if (seq_done) begin
          state_next = UFSP_IDLE;
        end else begin
          cnt_next = 17'(cnt_reg - 17'h00001);
        end
      end
      default: begin
        state_next = UFSP_IDLE;
        cnt_next = '0;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= UFSP_IDLE;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy_reg <= (state_next != UFSP_IDLE);
    end
  end

  // operands are frozen at the start edge, so the serial registers may move once busy ends
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_addr_reg <= '0;
      op_data_reg <= '0;
    end else if (start_prog || start_erase) begin
      op_addr_reg <= addr_reg;
      op_data_reg <= data_reg;
    end
  end

  assign busy = busy_reg;

  // array write at the end of a program sequence
  always_ff @(posedge hclk) begin
    if (commit_prog) begin
      mem[op_addr_reg] <= prog_word;
    end
  end

  // per-word written flags: erase clears every word of the chosen sector
  // erase and program never commit together, as the sequencer runs one at a time
  genvar gi;
  generate
    for (gi = 0; gi < `UFSP_WORDS; gi++) begin : g_word
      localparam logic [`UFSP_ADDR_W-1:0] IDX = `UFSP_ADDR_W'(gi);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          written_reg[gi] <= 1'b0;
        end else if (commit_erase && IDX[`UFSP_SECTOR_BIT] == op_addr_reg[`UFSP_SECTOR_BIT]) begin
          written_reg[gi] <= 1'b0;
        end else if (commit_prog && op_addr_reg == IDX) begin
          written_reg[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ============================================================
  // oscillator model: runs on enable or live update, output is a divide by four
  logic [7:0] osc_cnt_reg;
  logic osc_reg;
  logic [1:0] div_reg;
  logic divout_reg;
  wire logic osc_run;
  wire logic osc_wrap;
  wire logic osc_rise;
  wire logic [7:0] osc_cnt_next;
  wire logic [1:0] div_next;
  wire logic divout_next;
  assign osc_run = sync2_reg.clock_gen_enable | live_reg;
  assign osc_wrap = (osc_cnt_reg == OSC_HALF_M1);
  assign osc_cnt_next = osc_wrap ? 8'h00 : 8'(osc_cnt_reg + 8'h01);

  // the divider steps on each rising edge of the raw oscillator
  assign osc_rise = osc_wrap & ~osc_reg;
  assign div_next = osc_rise ? 2'(div_reg + 2'h1) : div_reg;
  // high for two of four raw periods: a square wave at a quarter of the rate
  assign divout_next = osc_rise ? (div_reg[0] ^ div_reg[1]) : divout_reg;

  // a stopped oscillator restarts from a known phase and drives a constant low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_cnt_reg <= '0;
      osc_reg <= 1'b0;
      div_reg <= '0;
      divout_reg <= 1'b0;
    end else if (!osc_run) begin
      osc_cnt_reg <= '0;
      osc_reg <= 1'b0;
      div_reg <= '0;
      divout_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_cnt_next;
      osc_reg <= osc_reg ^ osc_wrap;
      div_reg <= div_next;
      divout_reg <= divout_next;
    end
  end

  assign divided_clock_out = divout_reg;

  // ============================================================
  // ahb-lite slave: zero wait states, always okay
  logic wr_pend_reg;
  logic [11:0] wr_addr_reg;
  logic [31:0] hrdata_reg;
  wire logic accept;
  wire logic [11:0] a_off;
  wire logic [31:0] st_word;
  wire logic [31:0] rd_mux;
  assign accept = hsel & htrans[1] & hready;
  assign a_off = haddr[11:0];
  // write data arrives a cycle after its address, so the decode uses the held offset
  wire logic rd_take;
  wire logic wr_ctrl;
  assign rd_take = accept & ~hwrite;
  assign wr_ctrl = wr_pend_reg && (wr_addr_reg == `UFSP_OFF_CTRL);
  // status packs busy, live, sector, serial out and the address for software
  assign st_word = {7'h00, addr_reg, 12'h000, data_serial_out, sector, live_reg, busy_reg};
  assign rd_mux = (a_off == `UFSP_OFF_CTRL) ? {31'h00000000, live_reg} :
                  (a_off == `UFSP_OFF_STATUS) ? st_word :
                  (a_off == `UFSP_OFF_DATA) ? {16'h0000, data_reg} : 32'h00000000;

  // address phase captured here, write data taken in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg <= '0;
      live_reg <= `UFSP_CTRL_RESET;
    end else begin
      wr_pend_reg <= accept & hwrite;
      if (accept) begin
        wr_addr_reg <= a_off;
      end
      if (rd_take) begin
        hrdata_reg <= rd_mux;
      end
      if (wr_ctrl) begin
        live_reg <= hwdata[`UFSP_CTRL_LIVE_BIT];
      end
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign live_update_busy = live_reg;

endmodule : ufsp_top
`default_nettype wire

// >>> ufsp_sva.sv
// ufsp_sva.sv - port checker for the flash serial port
`timescale 1ns/1ps
`default_nettype none
module ufsp_sva #(
  parameter int unsigned PROG_CYCLES = 20,
  parameter int unsigned ERASE_CYCLES = 40
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // flash port
  input wire ufsp_pkg::ufsp_pins_t pins,
  input wire logic data_serial_out,
  input wire logic busy,
  input wire logic divided_clock_out,
  input wire logic live_update_busy
);
  import ufsp_pkg::*;
  // ====
  // helpers
  logic [16:0] busy_cnt;
  logic [7:0] idle_cnt;
  wire logic req_any = pins.program_req | pins.erase_req;
  wire logic osc_on = pins.clock_gen_enable | live_update_busy;
  // busy length and oscillator idle time; idle count saturates
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_cnt <= '0;
      idle_cnt <= '0;
    end else begin
      busy_cnt <= busy ? busy_cnt + 17'd1 : '0;
      idle_cnt <= osc_on ? '0 : idle_cnt + {7'd0, ~&idle_cnt};
    end
  end
  // ====
  // assertions
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // requests pass two flops and an edge detect, so allow a small window
  property p_prog_go; $rose(pins.program_req) && !busy && !live_update_busy
    |-> ##[2:6] $rose(busy); endproperty
  a_prog_go: assert property (p_prog_go) else $error("program did not raise busy");
  property p_erase_go; $rose(pins.erase_req) && !busy && !live_update_busy
    |-> ##[2:6] $rose(busy); endproperty
  a_erase_go: assert property (p_erase_go) else $error("erase did not raise busy");
  property p_busy_cause; $rose(busy) |-> $past(req_any, 3); endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose unasked");
  property p_busy_len; $fell(busy) |-> busy_cnt == PROG_CYCLES || busy_cnt == ERASE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_dout_hold; busy && $past(busy) |-> $stable(data_serial_out); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("data moved while busy");
  property p_div_idle; idle_cnt > 8'd80 |-> !divided_clock_out; endproperty
  a_div_idle: assert property (p_div_idle) else $error("divided clock not held low");
  property p_div_half; $rose(divided_clock_out) |-> ##32 !divided_clock_out; endproperty
  a_div_half: assert property (p_div_half) else $error("divided clock high too long");
  property p_live_osc; $rose(live_update_busy) && !divided_clock_out
    |-> ##[1:100] $rose(divided_clock_out); endproperty
  a_live_osc: assert property (p_live_osc) else $error("live update left clock off");
  // main scenarios
  c_busy: cover property ($fell(busy));
  c_live: cover property ($rose(live_update_busy));
  c_osc: cover property ($rose(divided_clock_out) && !pins.clock_gen_enable);
endmodule : ufsp_sva
bind ufsp_top ufsp_sva #(.PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_sva (
  .hclk(hclk), .hresetn(hresetn), .pins(pins), .data_serial_out(data_serial_out),
  .busy(busy), .divided_clock_out(divided_clock_out), .live_update_busy(live_update_busy));
`default_nettype wire

// >>> ufsp_ctl_model.sv
// ufsp_ctl_model.sv - controller in the logic array that drives the flash port
`timescale 1ns/1ps
`default_nettype none
module ufsp_ctl_model (
  // clock
  input wire logic hclk,
  // pins toward the port
  output var ufsp_pkg::ufsp_pins_t pins,
  // answers from the port
  input wire logic data_serial_out,
  input wire logic busy,
  input wire logic live_update_busy,
  input wire logic divided_clock_out
);
  import ufsp_pkg::*;
  initial pins = '0;
  // hold off while a sequence or live update runs
  task automatic wait_idle();
    for (int k = 0; k < 5000 && (busy || live_update_busy); k++) @(posedge hclk);
  endtask : wait_idle
  // one link edge, 100 ns period; stands low between frames
  task automatic tick(input bit is_addr);
    repeat (12) @(posedge hclk);
    if (is_addr) pins.addr_shift_clock <= 1'b1;
    else pins.data_shift_clock <= 1'b1;
    repeat (13) @(posedge hclk);
    pins.addr_shift_clock <= 1'b0;
    pins.data_shift_clock <= 1'b0;
  endtask : tick
  // msb-first frame; serial out is taken before each edge
  task automatic frame(input bit is_addr, input logic sel, input logic [15:0] v,
                       input int n, output logic [15:0] got);
    got = '0;
    for (int i = n - 1; i >= 0; i--) begin
      got[i] = data_serial_out;
      pins.addr_shift_select <= sel;
      pins.data_shift_select <= sel;
      pins.addr_serial_in <= v[i];
      pins.data_serial_in <= v[i];
      tick(is_addr);
    end
  endtask : frame
  // program or erase request; oscillator kept on through it
  task automatic pulse(input bit prog, input bit careful);
    if (careful) wait_idle();
    pins.clock_gen_enable <= 1'b1;
    repeat (4) @(posedge hclk);
    pins.program_req <= prog;
    pins.erase_req <= !prog;
    repeat (8) @(posedge hclk);
    pins.program_req <= 1'b0;
    pins.erase_req <= 1'b0;
  endtask : pulse
  // increments clocked by the divided oscillator routed back in, one per rise
  task automatic follow_osc(input int cycles);
    pins.addr_shift_select <= 1'b0;
    repeat (cycles) begin
      @(posedge hclk);
      pins.addr_shift_clock <= divided_clock_out;
    end
    @(posedge hclk);
    pins.addr_shift_clock <= 1'b0;
  endtask : follow_osc
endmodule : ufsp_ctl_model
`default_nettype wire

// >>> tb_top.sv
// tb_top.sv - self-checking bench for the flash serial port
`timescale 1ns/1ps
`default_nettype none
`include "ufsp_cfg.svh"
module tb_top;
  import ufsp_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, dout, busy, divclk, live;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] got;
  ufsp_pins_t pins;
  int mismatches, total_checks, n;
  // ====
  // design with short sequences, and its controller
  ufsp_top #(.PROG_CYCLES(60), .ERASE_CYCLES(120)) DUT (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .pins(pins), .data_serial_out(dout), .busy(busy),
    .divided_clock_out(divclk), .live_update_busy(live));
  ufsp_ctl_model ctl (.hclk(hclk), .pins(pins), .data_serial_out(dout), .busy(busy),
    .live_update_busy(live), .divided_clock_out(divclk));
  // 4 ns clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // hang guard, well above the run length
  initial begin
    repeat (40000) @(posedge hclk);
    mismatches++;
    summarize();
  end
  // ====
  // helpers
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h", $time, m, g);
    end
  endtask : chk
  // one single word transfer; read data lands in r
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic set_addr(input logic [8:0] a);
    ctl.wait_idle();
    ctl.frame(1'b1, 1'b1, {7'h0, a}, 9, got);
  endtask : set_addr
  // load, then fifteen shifts give the remaining bits
  task automatic read_data();
    ctl.frame(1'b0, 1'b0, 16'h0, 1, got);
    ctl.frame(1'b0, 1'b1, 16'h0, 16, got);
  endtask : read_data
  task automatic prog_word(input logic [8:0] a, input logic [15:0] d);
    set_addr(a);
    ctl.frame(1'b0, 1'b1, d, 16, got);
    ctl.pulse(1'b1, 1'b1);
  endtask : prog_word
  task automatic wait_rise();
    for (n = 0; n < 200 && divclk !== 1'b0; n++) @(posedge hclk);
    for (; n < 200 && divclk !== 1'b1; n++) @(posedge hclk);
  endtask : wait_rise
  // ====
  // scenarios
  task automatic t_reset();
    ahb(1'b1, 12'h010, 32'hFFFF_FFFF);
    ahb(1'b0, 12'h010, 32'h0);
    chk(r, 32'h0, "unmapped");
    ahb(1'b0, `UFSP_OFF_STATUS, 32'h0);
    chk(r, 32'h0, "status");
    chk({hresp, divclk}, 32'h0, "okay, clock low");
  endtask : t_reset
  task automatic t_read();
    set_addr(9'h1A5);
    read_data();
    chk(got, 16'hFFFF, "erased");
    ahb(1'b0, `UFSP_OFF_STATUS, 32'h0);
    chk({r[24:16], r[2]}, {9'h1A5, 1'b1}, "addr, sector");
  endtask : t_read
  task automatic t_program();
    prog_word(9'h005, 16'hA55A);
    chk(busy, 1'b1, "busy");
    ctl.tick(1'b1);
    ctl.wait_idle();
    ahb(1'b0, `UFSP_OFF_STATUS, 32'h0);
    chk({r[24:16], r[0]}, {9'h005, 1'b0}, "shift in busy");
    read_data();
    chk(got, 16'hA55A, "programmed");
    prog_word(9'h005, 16'h0FF0);
    set_addr(9'h005);
    read_data();
    chk(got, 16'h0550, "second write clears");
  endtask : t_program
  task automatic t_wrap();
    set_addr(9'h1FE);
    for (int i = 0; i < 2; i++) begin
      ctl.frame(1'b1, 1'b0, 16'h0, 1, got);
      ahb(1'b0, `UFSP_OFF_STATUS, 32'h0);
      chk(r[24:16], i ? 9'h000 : 9'h1FF, "increment");
    end
  endtask : t_wrap
  task automatic t_erase();
    prog_word(9'h105, 16'h1234);
    set_addr(9'h105);
    read_data();
    chk(got, 16'h1234, "sector one word");
    set_addr(9'h1C0);
    ctl.pulse(1'b0, 1'b1);
    set_addr(9'h105);
    read_data();
    chk(got, 16'hFFFF, "sector erased");
    set_addr(9'h005);
    read_data();
    chk(got, 16'h0550, "other sector kept");
  endtask : t_erase
  task automatic t_osc();
    ctl.pins.clock_gen_enable <= 1'b1;
    wait_rise();
    wait_rise();
    chk(n, 64, "divided period");
    set_addr(9'h1FF);
    wait_rise();
    ctl.follow_osc(96);
    ahb(1'b0, `UFSP_OFF_STATUS, 32'h0);
    chk(r[24:16], 9'h001, "osc-clocked increment");
    ctl.pins.clock_gen_enable <= 1'b0;
    repeat (120) @(posedge hclk);
    chk(divclk, 1'b0, "clock stopped");
    ahb(1'b1, `UFSP_OFF_CTRL, 32'h1);
    wait_rise();
    chk({live, n < 200}, 2'b11, "live clock");
    ctl.pulse(1'b1, 1'b0);
    chk(busy, 1'b0, "refused in live");
    ahb(1'b1, `UFSP_OFF_CTRL, 32'h0);
  endtask : t_osc
  // ====
  // main sequence
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_read();
    t_program();
    t_wrap();
    t_erase();
    t_osc();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
